// ### hdl/gmp_pkg.sv
// Shared constants and carriers for the tributary mapper and de-mapper.
package gmp_pkg;
	localparam int GMP_FIFO_DEPTH = 16;
	localparam int GMP_N_BITS = 8;
	localparam logic [13:0] GMP_GROUPS_STD = 14'h3B80;
	localparam logic [13:0] GMP_GROUPS_K4 = 14'h3B60;
	localparam logic [7:0] GMP_AIS_BYTE = 8'hFF;
	localparam logic [7:0] GMP_OCI_BYTE = 8'h66;
	localparam logic [7:0] GMP_FAS_A = 8'hF6;
	localparam logic [7:0] GMP_FAS_B = 8'h28;
	localparam logic [2:0] GMP_FAS_SPLIT = 3'h3;
	localparam logic [7:0] GMP_CRC8_POLY = 8'h07;
	localparam logic [4:0] GMP_CRC5_POLY = 5'h15;
	localparam logic [1:0] GMP_JC_NONE = 2'h0;
	localparam logic [1:0] GMP_JC_NEG = 2'h1;
	localparam logic [1:0] GMP_JC_POS = 2'h3;
	localparam logic [2:0] GMP_JC_CRC8_IDX = 3'h2;

	typedef enum logic [2:0] {
		GMP_K_PAY  = 3'h0,
		GMP_K_JC   = 3'h1,
		GMP_K_NJO  = 3'h2,
		GMP_K_PJO1 = 3'h3,
		GMP_K_PJO2 = 3'h4
	} gmp_kind_e;

	typedef enum logic [2:0] {
		GMP_C_ODU0 = 3'h0,
		GMP_C_ODU1 = 3'h1,
		GMP_C_ODU2 = 3'h2,
		GMP_C_ODU2E = 3'h3,
		GMP_C_ODU3 = 3'h4,
		GMP_C_FLEX = 3'h5
	} gmp_client_e;

	typedef enum logic [2:0] {
		GMP_O_2  = 3'h0,
		GMP_O_3  = 3'h1,
		GMP_O_4  = 3'h2,
		GMP_O_25 = 3'h3,
		GMP_O_50 = 3'h4,
		GMP_O_01 = 3'h5
	} gmp_cont_e;

	// One container byte position offered by the framer.
	typedef struct packed {
		logic      en;
		logic      mf;
		gmp_kind_e kind;
		logic [2:0] idx;
	} gmp_slot_s;

	// One client byte with its overhead position marks.
	typedef struct packed {
		logic [7:0] data;
		logic       fas;
		logic [2:0] fas_idx;
		logic       otu_oh;
	} gmp_client_s;
endpackage

// ### hdl/gmp_tributary_mapper.sv
// Tributary mapper and de-mapper with its client byte FIFO.
`timescale 1ns/1ns
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module gmp_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input  wire logic             clock,
	input  wire logic             rst,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data,
	output logic [$clog2(DEPTH):0] level
);
	localparam int AW = $clog2(DEPTH);
	initial if (DEPTH < 2 || (1 << AW) != DEPTH) $error("DEPTH must be a power of two");
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wp_q;
	logic [AW-1:0]    rp_q;
	logic             push;
	logic             pop;
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem_q[rp_q];
	always_ff @(posedge clock) begin
		if (push) mem_q[wp_q] <= in_data;
	end
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			wp_q <= '0;
			rp_q <= '0;
			level <= '0;
			in_ready <= 1'b0;
			out_valid <= 1'b0;
		end else begin
			wp_q <= wp_q + AW'(push);
			rp_q <= rp_q + AW'(pop);
			level <= level + (AW+1)'(push) - (AW+1)'(pop);
			in_ready <= (level + (AW+1)'(push) - (AW+1)'(pop)) != (AW+1)'(DEPTH);
			out_valid <= (level + (AW+1)'(push) - (AW+1)'(pop)) != '0;
		end
	end
endmodule // gmp_fifo

////////////////////////////////////////////////////////////////////////////////
module gmp_tributary_mapper import gmp_pkg::*; #(
	parameter int          M = 2,
	parameter logic [13:0] CM_NOM = 14'h3B00,
	parameter logic [13:0] CM_MIN = 14'h3AF0,
	parameter logic [13:0] CM_MAX = 14'h3B10
) (
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire gmp_client_e client_type,
	input  wire gmp_cont_e   cont_type,
	input  wire logic        unit_absent,
	input  wire logic        unit_removed,
	input  wire logic        client_valid,
	output logic             client_ready,
	input  wire gmp_client_s client_in,
	input  wire gmp_slot_s   tx_slot,
	output logic [7:0]       tx_data_q,
	output logic             tx_valid_q,
	input  wire gmp_slot_s   rx_slot,
	input  wire logic [7:0]  rx_byte,
	input  wire logic        rx_sf,
	output logic [7:0]       rx_data_q,
	output logic             rx_valid_q,
	output logic             crc8_err_q,
	output logic             crc5_err_q,
	output logic             underrun_q,
	output logic             unsupported_q
);
	initial if (M < 1 || M > 80) $error("M out of range");
	localparam int GW = $clog2(M + 1);
	localparam int LW = $clog2(GMP_FIFO_DEPTH) + 1;

	function automatic logic [7:0] f_crc8(input logic [15:0] d);
		logic [7:0] c;
		c = '0;
		for (int i = 15; i >= 0; i--)
			c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? GMP_CRC8_POLY : 8'h00);
		return c;
	endfunction

	function automatic logic [4:0] f_crc5(input logic [15:0] d);
		logic [4:0] c;
		c = '0;
		for (int i = 15; i >= 0; i--)
			c = {c[3:0], 1'b0} ^ ((c[4] ^ d[i]) ? GMP_CRC5_POLY : 5'h00);
		return c;
	endfunction

	function automatic logic f_ok(input gmp_client_e c, input gmp_cont_e k);
		case (k)
			GMP_O_01: f_ok = c == GMP_C_ODU0;
			GMP_O_2:  f_ok = c == GMP_C_ODU0 || c == GMP_C_FLEX;
			GMP_O_3:  f_ok = c == GMP_C_ODU0 || c == GMP_C_ODU2E || c == GMP_C_FLEX;
			GMP_O_25: f_ok = c != GMP_C_ODU3;
			default:  f_ok = 1'b1;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Client side: overhead extension, replacement patterns, FIFO.
	logic [7:0]    cli_byte;
	logic [7:0]    fifo_out;
	logic          fifo_ovalid;
	logic          pop;
	logic [LW-1:0] level;
	logic          async01;
	logic [13:0]   groups;
	assign async01 = cont_type == GMP_O_01;
	assign groups = cont_type == GMP_O_4 ? GMP_GROUPS_K4 : GMP_GROUPS_STD;

	always_comb begin
		cli_byte = client_in.data;
		if (client_in.fas)
			cli_byte = client_in.fas_idx < GMP_FAS_SPLIT ? GMP_FAS_A : GMP_FAS_B;
		else if (client_in.otu_oh)
			cli_byte = 8'h00;
		if (unit_absent)
			cli_byte = GMP_OCI_BYTE;
		else if (unit_removed)
			cli_byte = GMP_AIS_BYTE;
	end

	gmp_fifo #(.WIDTH(8), .DEPTH(GMP_FIFO_DEPTH)) u_fifo (
		.clock    (clock),
		.rst      (rst),
		.in_valid (client_valid || unit_absent || unit_removed),
		.in_ready (client_ready),
		.in_data  (cli_byte),
		.out_valid(fifo_ovalid),
		.out_ready(pop),
		.out_data (fifo_out),
		.level    (level)
	);

	////////////////////////////////////////////////////////////////////////////
	// Transmit: block count, JC bytes and group data/stuff decision.
	logic [13:0]   cm_q;
	logic [9:0]    cnd_q;
	logic [1:0]    just_q;
	logic [7:0]    jc_q [6];
	logic [14:0]   acc_q;
	logic [13:0]   gn_q;
	logic [GW-1:0] gb_q;
	logic          grp_q;
	logic          tx_is_data_q;
	logic [14:0]   acc_sum;
	logic          tx_data_now;
	logic          tx_pay;
	assign tx_pay = tx_slot.en && !tx_slot.mf && tx_slot.kind == GMP_K_PAY;
	assign acc_sum = acc_q + {1'b0, cm_q};

	always_comb begin
		tx_data_now = 1'b0;
		if (tx_slot.en && !tx_slot.mf)
			case (tx_slot.kind)
				GMP_K_PAY:  tx_data_now = async01 ? 1'b1 :
					(gb_q == '0 ? acc_sum >= {1'b0, groups} : grp_q);
				GMP_K_NJO:  tx_data_now = async01 && just_q == GMP_JC_NEG;
				GMP_K_PJO1: tx_data_now = async01 && just_q != GMP_JC_POS;
				GMP_K_PJO2: tx_data_now = async01;
				default:    tx_data_now = 1'b0;
			endcase
	end
	assign pop = tx_data_now && fifo_ovalid;

	// Counts are renewed at each multiframe start given by the framer.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			cm_q <= CM_NOM;
			cnd_q <= '0;
			just_q <= GMP_JC_NONE;
		end else if (tx_slot.en && tx_slot.mf) begin
			if (level < LW'(GMP_FIFO_DEPTH / 4) && cm_q > CM_MIN)
				cm_q <= cm_q - 14'h1;
			else if (level > LW'(GMP_FIFO_DEPTH * 3 / 4) && cm_q < CM_MAX)
				cm_q <= cm_q + 14'h1;
			cnd_q <= 10'(level);
			if (level > LW'(GMP_FIFO_DEPTH * 3 / 4))
				just_q <= GMP_JC_NEG;
			else if (level < LW'(GMP_FIFO_DEPTH / 4))
				just_q <= GMP_JC_POS;
			else
				just_q <= GMP_JC_NONE;
		end
	end

	always_comb begin
		jc_q[0] = cm_q[13:6];
		jc_q[1] = {cm_q[5:0], 2'h0};
		jc_q[2] = f_crc8({jc_q[0], jc_q[1]});
		jc_q[3] = {3'h0, cnd_q[9:5]};
		jc_q[4] = {cnd_q[4:0], 3'h0};
		jc_q[5] = {3'h0, f_crc5({jc_q[3], jc_q[4]})};
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			acc_q <= '0;
			gn_q <= 14'h1;
			gb_q <= '0;
			grp_q <= 1'b0;
		end else if (tx_slot.en && tx_slot.mf) begin
			acc_q <= '0;
			gn_q <= 14'h1;
			gb_q <= '0;
		end else if (tx_pay && !async01) begin
			if (gb_q == '0) begin
				grp_q <= tx_data_now;
				acc_q <= tx_data_now ? acc_sum - {1'b0, groups} : acc_sum;
			end
			if (gb_q == GW'(M - 1)) begin
				gb_q <= '0;
				if (gn_q < groups)
					gn_q <= gn_q + 14'h1;
			end else begin
				gb_q <= gb_q + GW'(1);
			end
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			tx_data_q <= 8'h00;
			tx_valid_q <= 1'b0;
			tx_is_data_q <= 1'b0;
			underrun_q <= 1'b0;
		end else begin
			tx_valid_q <= tx_slot.en && !tx_slot.mf;
			tx_is_data_q <= tx_data_now;
			underrun_q <= tx_data_now && !fifo_ovalid;
			if (tx_slot.kind == GMP_K_JC)
				tx_data_q <= async01 ? {6'h0, just_q} : jc_q[tx_slot.idx];
			else
				tx_data_q <= pop ? fifo_out : 8'h00;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			unsupported_q <= 1'b0;
		else
			unsupported_q <= !f_ok(client_type, cont_type);
	end

	////////////////////////////////////////////////////////////////////////////
	// Receive: JC decode and group extraction.
	logic [7:0]    rjc_q [6];
	logic [13:0]   rcm_q;
	logic [14:0]   racc_q;
	logic [GW-1:0] rgb_q;
	logic          rgrp_q;
	logic [14:0]   racc_sum;
	logic          rx_data_now;
	logic [13:0]   rcm_in;
	logic [1:0]    vote;
	logic          rx_pay;
	assign racc_sum = racc_q + {1'b0, rcm_q};
	assign rx_pay = rx_slot.en && !rx_slot.mf && rx_slot.kind == GMP_K_PAY;
	assign rcm_in = {rjc_q[0], rjc_q[1][7:2]};
	always_comb begin
		for (int b = 0; b < 2; b++)
			vote[b] = (rjc_q[0][b] & rjc_q[1][b]) | (rjc_q[0][b] & rjc_q[2][b])
				| (rjc_q[1][b] & rjc_q[2][b]);
	end

	always_comb begin
		rx_data_now = 1'b0;
		if (rx_slot.en && !rx_slot.mf)
			case (rx_slot.kind)
				GMP_K_PAY:  rx_data_now = async01 ? 1'b1 :
					(rgb_q == '0 ? racc_sum >= {1'b0, groups} : rgrp_q);
				GMP_K_NJO:  rx_data_now = async01 && vote == GMP_JC_NEG;
				GMP_K_PJO1: rx_data_now = async01 && vote != GMP_JC_POS;
				GMP_K_PJO2: rx_data_now = async01;
				default:    rx_data_now = 1'b0;
			endcase
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < 6; i++)
				rjc_q[i] <= 8'h00;
			rcm_q <= CM_NOM;
			crc8_err_q <= 1'b0;
			crc5_err_q <= 1'b0;
		end else if (rx_slot.en && rx_slot.mf) begin
			crc8_err_q <= !async01 && f_crc8({rjc_q[0], rjc_q[1]}) != rjc_q[2];
			crc5_err_q <= !async01
				&& f_crc5({rjc_q[3], rjc_q[4]}) != rjc_q[5][4:0];
			if (!async01 && f_crc8({rjc_q[0], rjc_q[1]}) == rjc_q[2])
				rcm_q <= rcm_in > groups ? groups : rcm_in;
		end else if (rx_slot.en && rx_slot.kind == GMP_K_JC && rx_slot.idx < 3'h6) begin
			rjc_q[rx_slot.idx] <= rx_byte;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			racc_q <= '0;
			rgb_q <= '0;
			rgrp_q <= 1'b0;
		end else if (rx_slot.en && rx_slot.mf) begin
			racc_q <= '0;
			rgb_q <= '0;
		end else if (rx_pay && !async01) begin
			if (rgb_q == '0) begin
				rgrp_q <= rx_data_now;
				racc_q <= rx_data_now ? racc_sum - {1'b0, groups} : racc_sum;
			end
			rgb_q <= rgb_q == GW'(M - 1) ? '0 : rgb_q + GW'(1);
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rx_data_q <= 8'h00;
			rx_valid_q <= 1'b0;
		end else begin
			rx_valid_q <= rx_data_now;
			rx_data_q <= rx_sf ? GMP_AIS_BYTE : rx_byte;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	stuff_zero_a: assert property (@(posedge clock) disable iff (rst)
		tx_valid_q && !tx_is_data_q && !$past(tx_slot.kind == GMP_K_JC) |-> tx_data_q == 8'h00)
		else $error("stuff byte not zero");
	pjo2_data_a: assert property (@(posedge clock) disable iff (rst)
		async01 && tx_slot.en && !tx_slot.mf && tx_slot.kind == GMP_K_PJO2 |=> tx_is_data_q)
		else $error("second opportunity not data");
	grp_range_a: assert property (@(posedge clock) disable iff (rst)
		gn_q >= 14'h1 && gn_q <= groups)
		else $error("group number out of range");
	grp_restart_a: assert property (@(posedge clock) disable iff (rst)
		tx_slot.en && tx_slot.mf |=> gn_q == 14'h1 && gb_q == '0 && acc_q == '0)
		else $error("group numbering not restarted");
	cm_bound_a: assert property (@(posedge clock) disable iff (rst)
		cm_q >= CM_MIN && cm_q <= CM_MAX)
		else $error("block count out of bounds");
	cm_step_a: assert property (@(posedge clock) disable iff (rst)
		$changed(cm_q) |-> cm_q == $past(cm_q) + 14'h1 || cm_q == $past(cm_q) - 14'h1)
		else $error("block count jumped");
	rx_ais_a: assert property (@(posedge clock) disable iff (rst)
		rx_sf && rx_data_now |=> rx_valid_q && rx_data_q == GMP_AIS_BYTE)
		else $error("alarm pattern not sent");
	grp_whole_a: assert property (@(posedge clock) disable iff (rst)
		tx_pay && !async01 && gb_q != '0 |=> tx_is_data_q == $past(grp_q))
		else $error("group mixes data and stuff");
	crc8_gen_a: assert property (@(posedge clock) disable iff (rst)
		tx_slot.en && !async01 && tx_slot.kind == GMP_K_JC && tx_slot.idx == GMP_JC_CRC8_IDX
		|=> tx_data_q == f_crc8({cm_q[13:6], cm_q[5:0], 2'h0}))
		else $error("JC3 not the CRC of JC1 and JC2");
	mf_seen_c: cover property (@(posedge clock) tx_slot.en && tx_slot.mf);
	stuff_grp_c: cover property (@(posedge clock) tx_pay && gb_q == '0 && !tx_data_now);
	crc_err_c: cover property (@(posedge clock) crc8_err_q);
endmodule // gmp_tributary_mapper

`default_nettype wire

// ### verification/gmp_framer_model.sv
// Framer partner model that offers container slots and loops the container back.
`timescale 1ns/1ns
`default_nettype none
module gmp_framer_model import gmp_pkg::*; (
	input  wire logic       clock,
	input  wire logic       start,
	input  wire logic       async_mode,
	input  wire logic [3:0] n_pay,
	input  wire logic [7:0] jc_mask,
	input  wire logic [7:0] tx_data_q,
	output var gmp_slot_s   tx_slot,
	output var gmp_slot_s   rx_slot,
	output logic [7:0]      rx_byte,
	output logic            busy
);
	gmp_slot_s  prev;
	logic [7:0] flip;

	initial begin
		tx_slot = '0;
		rx_slot = '0;
		rx_byte = 8'h00;
		busy = 1'b0;
		prev = '0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// One multiframe: marker first, then control bytes, opportunities (async mode only) and payload.
	always @(posedge clock) begin
		if (start && !busy) begin
			busy = 1'b1;
			@(negedge clock);
			tx_slot = '{1'b1, 1'b1, GMP_K_PAY, 3'h0};
			for (int k = 0; k < 6 + n_pay; k++) begin
				@(negedge clock);
				if (k < 3 || (k < 6 && !async_mode))
					tx_slot = '{1'b1, 1'b0, GMP_K_JC, 3'(k)};
				else if (k < 6)
					tx_slot = '{1'b1, 1'b0, gmp_kind_e'(3'(k - 1)), 3'h0};
				else
					tx_slot = '{1'b1, 1'b0, GMP_K_PAY, 3'h0};
			end
			@(negedge clock);
			tx_slot = '0;
			busy = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Loopback: a byte and its slot return together; idle cycles show a toggling byte.
	assign flip = (prev.kind == GMP_K_JC && (prev.idx == 3'h0 || prev.idx == 3'h3)) ? jc_mask : 8'h00;
	always @(posedge clock) prev <= tx_slot;
	always @(negedge clock) begin
		rx_slot <= prev;
		if (prev.en && !prev.mf)
			rx_byte <= tx_data_q ^ flip;
		else
			rx_byte <= ~rx_byte;
	end
endmodule // gmp_framer_model
`default_nettype wire

// ### verification/gmp_tributary_mapper_bench.sv
// Self-checking bench for the tributary mapper and de-mapper.
`timescale 1ns/1ns
`default_nettype none
module gmp_tributary_mapper_bench import gmp_pkg::*;;
	localparam logic [13:0] G = GMP_GROUPS_STD;
	logic        clock = 1'b0;
	logic        rst = 1'b1;
	gmp_client_e client_type = GMP_C_ODU0;
	gmp_cont_e   cont_type = GMP_O_2;
	logic        unit_absent = 1'b0;
	logic        unit_removed = 1'b0;
	logic        client_valid = 1'b0;
	gmp_client_s client_in = '0;
	logic        rx_sf = 1'b0;
	logic        start = 1'b0;
	logic        async_mode = 1'b0;
	logic [3:0]  n_pay = 4'h0;
	logic [7:0]  jc_mask = 8'h00;
	logic        client_ready, tx_valid_q, rx_valid_q, busy;
	logic        crc8_err_q, crc5_err_q, underrun_q, unsupported_q;
	logic [7:0]  tx_data_q, rx_data_q, rx_byte;
	gmp_slot_s   tx_slot, rx_slot;
	logic [7:0]  txq[$], rxq[$], cq[$], e[$];
	int          err_count = 0;
	int          num_checks = 0;
	int          un_cnt = 0;

	gmp_tributary_mapper #(.M(2), .CM_NOM(G), .CM_MIN(14'h3B70), .CM_MAX(G)) uut (
		.clock(clock), .rst(rst), .client_type(client_type), .cont_type(cont_type),
		.unit_absent(unit_absent), .unit_removed(unit_removed), .client_valid(client_valid),
		.client_ready(client_ready), .client_in(client_in), .tx_slot(tx_slot),
		.tx_data_q(tx_data_q), .tx_valid_q(tx_valid_q), .rx_slot(rx_slot), .rx_byte(rx_byte),
		.rx_sf(rx_sf), .rx_data_q(rx_data_q), .rx_valid_q(rx_valid_q), .crc8_err_q(crc8_err_q),
		.crc5_err_q(crc5_err_q), .underrun_q(underrun_q), .unsupported_q(unsupported_q));
	gmp_framer_model framer (
		.clock(clock), .start(start), .async_mode(async_mode), .n_pay(n_pay),
		.jc_mask(jc_mask), .tx_data_q(tx_data_q), .tx_slot(tx_slot), .rx_slot(rx_slot),
		.rx_byte(rx_byte), .busy(busy));

	always #4 clock = ~clock;
	always @(negedge clock) begin
		if (tx_valid_q === 1'b1)
			txq.push_back(tx_data_q);
		if (rx_valid_q === 1'b1)
			rxq.push_back(rx_data_q);
		if (underrun_q === 1'b1)
			un_cnt++;
	end

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [7:0] crc8(input logic [15:0] v);
		logic [7:0] c = 8'h00;
		for (int i = 15; i >= 0; i--)
			c = {c[6:0], 1'b0} ^ ((c[7] ^ v[i]) ? GMP_CRC8_POLY : 8'h00);
		return c;
	endfunction
	function automatic logic [4:0] crc5(input logic [15:0] v);
		logic [4:0] c = 5'h00;
		for (int i = 15; i >= 0; i--)
			c = {c[3:0], 1'b0} ^ ((c[4] ^ v[i]) ? GMP_CRC5_POLY : 5'h00);
		return c;
	endfunction
	task automatic check_byte(input string nm, input logic [7:0] x, input logic [7:0] g);
		num_checks++;
		if (g !== x) begin
			err_count++;
			$display("unexpected %s: expected %h, seen %h", nm, x, g);
		end
	endtask
	task automatic check_bit(input string nm, input logic x, input logic g);
		num_checks++;
		if (g !== x) begin
			err_count++;
			$display("unexpected %s: expected %b, seen %b", nm, x, g);
		end
	endtask
	task automatic check_q(input string nm, input logic [7:0] x[$], input logic [7:0] g[$]);
		check_bit({nm, " count"}, 1'b1, x.size() == g.size());
		foreach (x[i])
			check_byte(nm, x[i], i < g.size() ? g[i] : 8'hxx);
	endtask
	task automatic summarize();
		$display("checks %0d, mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic reset_dut(input gmp_cont_e ct, input gmp_client_e cl);
		@(negedge clock);
		rst = 1'b1;
		cont_type = ct;
		client_type = cl;
		repeat (2) @(negedge clock);
		rst = 1'b0;
		cq.delete();
		repeat (2) @(negedge clock);
	endtask
	// Marks: 1 and 2 alignment bytes, 3 overhead byte, 4 unit absent, 5 unit removed.
	task automatic push(input logic [7:0] d, input logic [2:0] mk);
		@(negedge clock);
		client_valid = mk < 4 && client_ready;
		unit_absent = mk == 4 && client_ready;
		unit_removed = mk == 5 && client_ready;
		client_in = '{d, mk == 1 || mk == 2, (mk == 2) ? 3'h4 : 3'h0, mk == 3};
		if (client_ready === 1'b1)
			cq.push_back(mk == 4 ? GMP_OCI_BYTE : mk == 5 ? GMP_AIS_BYTE : mk == 1 ? GMP_FAS_A :
				mk == 2 ? GMP_FAS_B : mk == 3 ? 8'h00 : d);
	endtask
	task automatic frame(input logic am, input logic [3:0] np, input logic [7:0] mk);
		int n = 0;
		@(negedge clock);
		client_valid = 1'b0;
		unit_absent = 1'b0;
		unit_removed = 1'b0;
		txq.delete();
		rxq.delete();
		un_cnt = 0;
		async_mode = am;
		n_pay = np;
		jc_mask = mk;
		start = 1'b1;
		@(negedge clock);
		start = 1'b0;
		while (busy && n < 100) begin
			@(negedge clock);
			n++;
		end
		repeat (3) @(negedge clock);
	endtask
	task automatic jc_exp(input logic [9:0] cnd);
		logic [7:0] j0 = G[13:6];
		logic [7:0] j1 = {G[5:0], 2'b00};
		logic [7:0] j3 = {3'b000, cnd[9:5]};
		logic [7:0] j4 = {cnd[4:0], 3'b000};
		e = '{j0, j1, crc8({j0, j1}), j3, j4, {3'b000, crc5({j3, j4})}};
	endtask
	task automatic run_gmp(input logic [7:0] mk);
		for (int i = 0; i < 8; i++)
			push(8'(8'hC0 + i), 3'(i < 6 ? i : 0));
		jc_exp(10'd8);
		repeat (8) e.push_back(cq.pop_front());
		frame(1'b0, 4'h8, mk);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_async();
		reset_dut(GMP_O_01, GMP_C_ODU0);
		push(8'hA0, 3'h0);
		push(8'hA1, 3'h0);
		e = '{8'h03, 8'h03, 8'h03, 8'h00, 8'h00};
		repeat (2) e.push_back(cq.pop_front());
		frame(1'b1, 4'h1, 8'h00);
		check_q("async plus", e, txq);
		check_q("async plus demap", e[5:$], rxq);
		repeat (20) push(8'(8'h40 + cq.size()), 3'h0);
		check_bit("fifo full", 1'b1, cq.size() == GMP_FIFO_DEPTH);
		e = '{8'h01, 8'h01, 8'h01};
		repeat (5) e.push_back(cq.pop_front());
		frame(1'b1, 4'h2, 8'h00);
		check_q("async minus", e, txq);
		check_q("async minus demap", e[3:$], rxq);
		e = '{8'h00, 8'h00, 8'h00, 8'h00};
		repeat (2) e.push_back(cq.pop_front());
		frame(1'b1, 4'h0, 8'h02);
		check_q("async zero", e, txq);
		check_q("async vote demap", e[4:$], rxq);
	endtask
	task automatic t_gmp();
		reset_dut(GMP_O_2, GMP_C_ODU0);
		run_gmp(8'h00);
		check_q("gmp frame", e, txq);
		run_gmp(8'h00);
		check_q("gmp frame", e, txq);
		check_q("demap", e[6:$], rxq);
		check_bit("crc8 flag", 1'b0, crc8_err_q);
	endtask
	task automatic t_fault();
		reset_dut(GMP_O_2, GMP_C_ODU0);
		run_gmp(8'h00);
		run_gmp(8'h01);
		rx_sf = 1'b1;
		run_gmp(8'h00);
		check_bit("crc8 flag", 1'b1, crc8_err_q);
		check_bit("crc5 flag", 1'b1, crc5_err_q);
		check_bit("fail data", 1'b1, rxq.size() > 0);
		foreach (rxq[i])
			check_byte("fail byte", GMP_AIS_BYTE, rxq[i]);
		rx_sf = 1'b0;
	endtask
	task automatic t_underrun();
		reset_dut(GMP_O_2, GMP_C_ODU0);
		for (int i = 0; i < 4; i++)
			push(8'(8'h10 + i), 3'h0);
		jc_exp(10'd4);
		repeat (4) e.push_back(cq.pop_front());
		e.push_back(8'h00);
		e.push_back(8'h00);
		frame(1'b0, 4'h6, 8'h00);
		check_q("underrun frame", e, txq);
		check_bit("underrun", 1'b1, un_cnt > 0);
	endtask
	task automatic t_pairs();
		gmp_cont_e ct[8] = '{GMP_O_2, GMP_O_2, GMP_O_3, GMP_O_3, GMP_O_25, GMP_O_25, GMP_O_4, GMP_O_50};
		gmp_client_e cl[8] = '{GMP_C_ODU0, GMP_C_ODU3, GMP_C_ODU2E, GMP_C_ODU1, GMP_C_ODU1,
			GMP_C_ODU3, GMP_C_ODU3, GMP_C_FLEX};
		logic [7:0] bad = 8'b00101010;
		for (int i = 0; i < 8; i++) begin
			@(negedge clock);
			cont_type = ct[i];
			client_type = cl[i];
			repeat (3) @(negedge clock);
			check_bit("unsupported", bad[i], unsupported_q);
		end
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		#40000;
		err_count++;
		summarize();
	end
	initial begin
		t_async();
		t_gmp();
		t_fault();
		t_underrun();
		t_pairs();
		summarize();
	end
endmodule // gmp_tributary_mapper_bench
`default_nettype wire
